// ---- hw/wvm_pkg.sv ----
// wvm_pkg: constants, types and register map of the weighted video mixer.
// assumes a single 100 MHz clock domain and a classic Wishbone register port.
package wvm_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned PIX_W     = 12;
  localparam int unsigned OUT_W     = 13;
  localparam int unsigned DWORD_W   = 15;
  localparam int unsigned FIELD_W   = 3;
  localparam int unsigned MAX_DELAY = 7;
  localparam int unsigned INHERENT_STAGES = 6;

  // ==========================================================================
  // delay word field positions
  localparam int unsigned FLD_PIX_A = 0;
  localparam int unsigned FLD_PIX_B = 3;
  localparam int unsigned FLD_MIX   = 6;
  localparam int unsigned FLD_FMT   = 9;
  localparam int unsigned FLD_RND   = 12;
  localparam logic [DWORD_W-1:0] DWORD_RESET = 15'h0000;

  // ==========================================================================
  // arithmetic constants
  localparam logic [PIX_W-1:0] MIX_ONE     = 12'h800;
  localparam logic [12:0]      MIX_ONE_EXT = 13'h0800;
  localparam int unsigned      FRAC_SHIFT  = 10;
  localparam logic [1:0] RND_8  = 2'h0;
  localparam logic [1:0] RND_10 = 2'h1;
  localparam logic [1:0] RND_12 = 2'h2;
  localparam logic [1:0] RND_13 = 2'h3;
  localparam logic signed [22:0] LIM_UNS_MAX = 23'sh001FFF;
  localparam logic signed [22:0] LIM_SGN_MAX = 23'sh000FFF;
  localparam logic signed [22:0] LIM_SGN_MIN = -23'sh001000;

  // ==========================================================================
  // register map (byte addresses) and fields
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_DELAY  = 4'h8;
  localparam int unsigned CTRL_FORCE_BYPASS = 0;
  localparam int unsigned STAT_SAT          = 0;
  localparam int unsigned STAT_BYPASS       = 1;

  // ==========================================================================
  // types
  typedef struct packed {
    logic       fmt_unsigned;
    logic [1:0] rnd;
  } wvm_ctl_s;

  typedef struct packed {
    logic [2:0] rnd;
    logic [2:0] fmt;
    logic [2:0] mix;
    logic [2:0] pix_b;
    logic [2:0] pix_a;
  } wvm_dword_s;

endpackage : wvm_pkg

// ---- hw/wvm_delay_line.sv ----
// wvm_delay_line: programmable 0..7 cycle delay for one input path.
// assumes the select changes only while the path carries no meaningful data.
`timescale 1ns/1ns
module wvm_delay_line
#(
  parameter int unsigned W = 12
)
(
  input  wire logic         clk_i,
  input  wire logic [2:0]   sel_i,
  input  wire logic [W-1:0] din_i,
  output logic      [W-1:0] dout_o
);
  import wvm_pkg::*;

  logic [W-1:0] tap_q [MAX_DELAY];

  // ==========================================================================
  // shift chain, no reset: data path only
  always_ff @(posedge clk_i)
  begin
    tap_q[0] <= din_i;
    for (int i = 1; i < MAX_DELAY; i++)
    begin
      tap_q[i] <= tap_q[i-1];
    end
  end

  always_comb
  begin
    if (sel_i == 3'h0)
    begin
      dout_o = din_i;
    end
    else
    begin
      dout_o = tap_q[sel_i - 3'h1];
    end
  end

endmodule : wvm_delay_line

// ---- hw/wvm_mixer.sv ----
// wvm_mixer: pipelined weighted mixer of two 12-bit pixel streams.
// assumes all stream inputs synchronous to clk_i; strobe, serial, bypass are resynchronised.
//
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
module wvm_mixer
(
  input  wire logic                          clk_i,
  input  wire logic                          reset_n_i,
  input  wire logic [wvm_pkg::PIX_W-1:0]     pixel_a_in_i,
  input  wire logic [wvm_pkg::PIX_W-1:0]     pixel_b_in_i,
  input  wire logic [wvm_pkg::PIX_W-1:0]     mix_factor_in_i,
  input  wire logic                          mix_factor_capture_en_i,
  input  wire logic                          input_format_sel_n_i,
  input  wire logic [1:0]                    round_precision_sel_i,
  input  wire logic                          delay_word_shift_strobe_n_i,
  input  wire logic                          delay_word_serial_in_i,
  input  wire logic                          delay_bypass_i,
  input  wire logic                          output_enable_n_i,
  output logic      [wvm_pkg::OUT_W-1:0]     mixed_pixel_out_o,
  output logic                               mixed_pixel_oe_n_o,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [3:0]                    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o
);
  import wvm_pkg::*;

  // ==========================================================================
  // helpers
  function automatic logic [2:0] drop_bits(input logic [1:0] rnd);
    case (rnd)
      RND_8:   drop_bits = 3'h5;
      RND_10:  drop_bits = 3'h3;
      RND_12:  drop_bits = 3'h1;
      default: drop_bits = 3'h0;
    endcase
  endfunction : drop_bits

  function automatic logic signed [12:0] ext_pix(input logic [PIX_W-1:0] p, input logic uns);
    ext_pix = uns ? $signed({1'b0, p}) : $signed({p[PIX_W-1], p});
  endfunction : ext_pix

  // ==========================================================================
  // reset release and input resynchronisers
  logic [1:0] rst_sync_q;
  logic       rst_n;
  logic [2:0] strobe_sync_q;
  logic [1:0] serial_sync_q;
  logic [1:0] bypass_sync_q;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_sync_q <= 2'h0;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // asynchronous pins sampled here; only the second stage onward is looked at
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strobe_sync_q <= 3'h7;
      serial_sync_q <= 2'h0;
      bypass_sync_q <= 2'h0;
    end
    else
    begin
      strobe_sync_q <= {strobe_sync_q[1:0], delay_word_shift_strobe_n_i};
      serial_sync_q <= {serial_sync_q[0], delay_word_serial_in_i};
      bypass_sync_q <= {bypass_sync_q[0], delay_bypass_i};
    end
  end

  // ==========================================================================
  // delay word shift register and bypass
  logic               strobe_rise;
  logic [DWORD_W-1:0] dword_q;
  logic               force_bypass_q;
  logic               bypass_eff;
  wvm_dword_s         dword_eff;

  assign strobe_rise = strobe_sync_q[1] & ~strobe_sync_q[2];
  assign bypass_eff  = bypass_sync_q[1] | force_bypass_q;
  assign dword_eff   = bypass_eff ? wvm_dword_s'(DWORD_RESET) : wvm_dword_s'(dword_q);

  // extra strobes simply keep the last 15 bits shifted in
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dword_q <= DWORD_RESET;
    end
    else if (strobe_rise)
    begin
      dword_q <= {serial_sync_q[1], dword_q[DWORD_W-1:1]};
    end
  end

  // ==========================================================================
  // stage 1: capture
  logic [PIX_W-1:0] pix_a_q;
  logic [PIX_W-1:0] pix_b_q;
  logic [PIX_W-1:0] mix_q;
  wvm_ctl_s         ctl1_q;

  always_ff @(posedge clk_i)
  begin
    pix_a_q <= pixel_a_in_i;
    pix_b_q <= pixel_b_in_i;
    ctl1_q  <= '{fmt_unsigned: input_format_sel_n_i, rnd: round_precision_sel_i};
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mix_q <= MIX_ONE;
    end
    else if (mix_factor_capture_en_i)
    begin
      mix_q <= mix_factor_in_i[PIX_W-1] ? MIX_ONE : mix_factor_in_i;
    end
  end

  // ==========================================================================
  // per-input programmable delays
  logic [PIX_W-1:0] dly_a;
  logic [PIX_W-1:0] dly_b;
  logic [PIX_W-1:0] dly_m;
  logic [0:0]       dly_f;
  logic [1:0]       dly_r;

  wvm_delay_line #(.W(PIX_W)) u_dly_a (.clk_i(clk_i), .sel_i(dword_eff.pix_a), .din_i(pix_a_q), .dout_o(dly_a));
  wvm_delay_line #(.W(PIX_W)) u_dly_b (.clk_i(clk_i), .sel_i(dword_eff.pix_b), .din_i(pix_b_q), .dout_o(dly_b));
  wvm_delay_line #(.W(PIX_W)) u_dly_m (.clk_i(clk_i), .sel_i(dword_eff.mix), .din_i(mix_q), .dout_o(dly_m));
  wvm_delay_line #(.W(1)) u_dly_f (.clk_i(clk_i), .sel_i(dword_eff.fmt), .din_i(ctl1_q.fmt_unsigned), .dout_o(dly_f));
  wvm_delay_line #(.W(2)) u_dly_r (.clk_i(clk_i), .sel_i(dword_eff.rnd), .din_i(ctl1_q.rnd), .dout_o(dly_r));

  // ==========================================================================
  // stages 2..5: weight, sum, round, saturate
  logic signed [25:0] prod_a_q;
  logic signed [25:0] prod_b_q;
  logic signed [26:0] sum_q;
  logic signed [17:0] rnd_val_q;
  logic [OUT_W-1:0]   sat_val_q;
  logic               sat_ovf_q;
  wvm_ctl_s           ctl2_q;
  wvm_ctl_s           ctl3_q;
  wvm_ctl_s           ctl4_q;
  wvm_ctl_s           ctl5_q;
  wvm_ctl_s           ctl6_q;
  logic               out_ovf_q;

  logic signed [12:0] w_a;
  logic signed [12:0] w_b;
  logic signed [27:0] rnd_sum;
  logic signed [22:0] full_val;
  logic signed [22:0] lim_hi;
  logic signed [22:0] lim_lo;
  logic signed [22:0] low_mask;

  assign w_a      = $signed({1'b0, dly_m});
  assign w_b      = $signed(MIX_ONE_EXT - {1'b0, dly_m});
  assign rnd_sum  = 28'(sum_q) + (28'sh1 <<< (4'd9 + {1'b0, drop_bits(ctl3_q.rnd)}));
  assign full_val = 23'(rnd_val_q) <<< drop_bits(ctl4_q.rnd);
  assign low_mask = ~((23'sh1 <<< drop_bits(ctl4_q.rnd)) - 23'sh1);
  assign lim_hi   = (ctl4_q.fmt_unsigned ? LIM_UNS_MAX : LIM_SGN_MAX) & low_mask;
  assign lim_lo   = ctl4_q.fmt_unsigned ? 23'sh0 : LIM_SGN_MIN;

  always_ff @(posedge clk_i)
  begin
    // weights are in 2^-11 units; the doubling folds into a 10-bit shift
    prod_a_q  <= ext_pix(dly_a, dly_f[0]) * w_a;
    prod_b_q  <= ext_pix(dly_b, dly_f[0]) * w_b;
    ctl2_q    <= '{fmt_unsigned: dly_f[0], rnd: dly_r};
    sum_q     <= 27'(prod_a_q) + 27'(prod_b_q);
    ctl3_q    <= ctl2_q;
    rnd_val_q <= 18'(rnd_sum >>> (4'(FRAC_SHIFT) + {1'b0, drop_bits(ctl3_q.rnd)}));
    ctl4_q    <= ctl3_q;
    ctl5_q    <= ctl4_q;
    if (full_val > lim_hi)
    begin
      sat_val_q <= lim_hi[OUT_W-1:0];
      sat_ovf_q <= 1'b1;
    end
    else if (full_val < lim_lo)
    begin
      sat_val_q <= lim_lo[OUT_W-1:0];
      sat_ovf_q <= 1'b1;
    end
    else
    begin
      sat_val_q <= full_val[OUT_W-1:0];
      sat_ovf_q <= 1'b0;
    end
  end

  // ==========================================================================
  // stage 6: output register and three-state control
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mixed_pixel_out_o <= '0;
      ctl6_q            <= '0;
      out_ovf_q         <= 1'b0;
    end
    else
    begin
      mixed_pixel_out_o <= sat_val_q;
      ctl6_q            <= ctl5_q;
      out_ovf_q         <= sat_ovf_q;
    end
  end

  // enable must act without a clock, so it is the one output not taken from a flop
  assign mixed_pixel_oe_n_o = output_enable_n_i;

  // ==========================================================================
  // wishbone slave: one-wait answer, unmapped reads return zero
  logic sat_sticky_q;
  logic wb_req;
  logic wb_wr;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_req & wb_we_i & wb_sel_i[0];

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i)
      begin
        case (wb_adr_i)
          REG_CTRL:   wb_dat_o[CTRL_FORCE_BYPASS] <= force_bypass_q;
          REG_STATUS: wb_dat_o[STAT_BYPASS:STAT_SAT] <= {bypass_eff, sat_sticky_q};
          REG_DELAY:  wb_dat_o[DWORD_W-1:0] <= dword_eff;
          default:    wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      force_bypass_q <= 1'b0;
    end
    else if (wb_wr && wb_adr_i == REG_CTRL)
    begin
      force_bypass_q <= wb_dat_i[CTRL_FORCE_BYPASS];
    end
  end

  // a new overflow in the clearing cycle keeps the flag set
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sat_sticky_q <= 1'b0;
    end
    else if (out_ovf_q)
    begin
      sat_sticky_q <= 1'b1;
    end
    else if (wb_wr && wb_adr_i == REG_STATUS && wb_dat_i[STAT_SAT])
    begin
      sat_sticky_q <= 1'b0;
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  a_mix_hold:     assert property (!mix_factor_capture_en_i |=> $stable(mix_q))
    else $error("mix factor changed while capture disabled");
  a_mix_sat:      assert property (mix_factor_capture_en_i && mix_factor_in_i[11] |=> mix_q == MIX_ONE)
    else $error("mix factor above one not forced to one");
  a_bypass_zero:  assert property (bypass_eff |-> dword_eff == wvm_dword_s'(DWORD_RESET))
    else $error("delay word not zero under bypass");
  a_shift_in:     assert property (strobe_rise |=> dword_q == {$past(serial_sync_q[1]), $past(dword_q[14:1])})
    else $error("delay word shift wrong");
  a_shift_idle:   assert property (!strobe_rise |=> $stable(dword_q))
    else $error("delay word moved without strobe");
  a_oe_follow:    assert property (mixed_pixel_oe_n_o == output_enable_n_i)
    else $error("output enable does not follow its pin");
  a_round_clear:  assert property ((mixed_pixel_out_o & ((13'h1 << drop_bits(ctl6_q.rnd)) - 13'h1)) == 13'h0)
    else $error("bits below selected precision not cleared");
  a_sat_clamp:    assert property (out_ovf_q && ctl6_q.fmt_unsigned |->
                                   mixed_pixel_out_o == 13'h0 || mixed_pixel_out_o[12:5] == 8'hFF)
    else $error("unsigned overflow not clamped to a limit");
  a_ctl_latency:  assert property (dword_eff == '0 && $past(dword_eff, 6) == '0 |->
                                   ctl6_q == $past({input_format_sel_n_i, round_precision_sel_i}, 6))
    else $error("format controls lost alignment with data");

  c_overflow:     cover property (out_ovf_q);
  c_strobe:       cover property (strobe_rise ##[1:8] strobe_rise);
  c_bypass:       cover property (bypass_eff && strobe_rise);
  c_mix_hold:     cover property (!mix_factor_capture_en_i [*3]);

endmodule : wvm_mixer

// ---- testbench/wvm_delay_loader.sv ----
// wvm_delay_loader: model of the party that shifts the delay word in serially.
// assumes clk_i is the mixer clock; strobe phases are timed in its cycles.
`timescale 1ns/1ns
module wvm_delay_loader
(
  input  wire logic clk_i,
  output logic      strobe_n_o,
  output logic      serial_o
);
  // ==========================================================================
  // idle strobe high; each phase 4 clocks, above the 3 the synchroniser needs
  initial
  begin
    strobe_n_o = 1'b1;
    serial_o   = 1'b0;
  end

  task automatic load(input logic [14:0] word);
    for (int i = 0; i < 15; i++)
    begin
      @(posedge clk_i);
      strobe_n_o <= 1'b0;
      serial_o   <= word[i];
      repeat (4) @(posedge clk_i);
      strobe_n_o <= 1'b1;
      repeat (3) @(posedge clk_i);
    end
    serial_o <= ~word[14];  // released line must not keep the last bit
  endtask : load
endmodule : wvm_delay_loader

// ---- testbench/weighted_video_mixer_bench.sv ----
// weighted_video_mixer_bench: random streams against an integer model.
// assumes wvm_pkg and the mixer top; the loader plays the configuring party.
`timescale 1ns/1ns
module weighted_video_mixer_bench;
  import wvm_pkg::*;
  logic        clk, rst_n, mix_en, fmt, oe_n, byp, stb_n, ser, oe_o, cyc, stb, we, ack;
  logic [11:0] pa, pb, pm;
  logic [1:0]  rnd;
  logic [12:0] dout;
  logic [3:0]  adr;
  logic [31:0] wdat, rd_o, rdat;
  int          n_errors, samples_checked, t, settle, cycles, dw, sat_seen, mstore;
  bit          run, chk, extremes;
  int          ha[1024], hb[1024], hm[1024], hf[1024], hr[1024];
  logic [14:0] words[3] = '{15'h7FFF, 15'b111_010_101_000_011, 15'b001_110_000_111_100};

  wvm_mixer i_dut (.clk_i(clk), .reset_n_i(rst_n), .pixel_a_in_i(pa), .pixel_b_in_i(pb),
    .mix_factor_in_i(pm), .mix_factor_capture_en_i(mix_en), .input_format_sel_n_i(fmt),
    .round_precision_sel_i(rnd), .delay_word_shift_strobe_n_i(stb_n), .delay_word_serial_in_i(ser),
    .delay_bypass_i(byp), .output_enable_n_i(oe_n), .mixed_pixel_out_o(dout),
    .mixed_pixel_oe_n_o(oe_o), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rd_o), .wb_ack_o(ack));
  wvm_delay_loader i_loader (.clk_i(clk), .strobe_n_o(stb_n), .serial_o(ser));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================================
  // shared tasks
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rdat = rd_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20)
    begin
      n_errors++;
      tally_and_finish();
    end
  endtask : wb

  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
    wb(1'b0, a, 32'h0);
    check(what, rdat, exp);
  endtask : rd

  function automatic logic [11:0] pick();
    int k;
    k = $urandom % 8;
    if (extremes && k < 4)
      return k == 0 ? 12'h7FF : k == 1 ? 12'h800 : k == 2 ? 12'hFFF : 12'h000;
    return 12'($urandom);
  endfunction : pick

  function automatic int at(int sh);
    return (t - 5 - sh) % 1024;
  endfunction : at

  // ==========================================================================
  // stimulus and reference model
  always @(posedge clk)
    if (run)
    begin
      pa     <= pick();
      pb     <= pick();
      pm     <= 12'($urandom);
      mix_en <= 1'($urandom);
      fmt    <= 1'($urandom);
      rnd    <= 2'($urandom);
      oe_n   <= 1'($urandom);
    end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end

  always @(posedge clk)
  begin
    if (!rst_n)
      mstore = 2048;
    else if (mix_en === 1'b1)
      mstore = pm[11] ? 2048 : int'(pm);
    t++;
    ha[t % 1024] = pa;
    hb[t % 1024] = pb;
    hm[t % 1024] = mstore;
    hf[t % 1024] = fmt;
    hr[t % 1024] = rnd;
    if (settle > 0)
      settle--;
    #1;
    if (chk && settle == 0)
      check_out();
  end

  task automatic check_out();
    int s, r, d, hi, lo, a, b, m, f;
    f = hf[at(dw >> 9 & 7)];
    a = ha[at(dw & 7)];
    b = hb[at(dw >> 3 & 7)];
    m = hm[at(dw >> 6 & 7)];
    d = 5 - 2 * hr[at(dw >> 12 & 7)];
    if (!f && a >= 2048)
      a -= 4096;
    if (!f && b >= 2048)
      b -= 4096;
    if (d < 0)
      d = 0;
    s = a * m + b * (2048 - m);
    r = (s + (1 << (9 + d))) >>> 10;
    r = r & ~((1 << d) - 1);
    hi = (f ? 8191 : 4095) & ~((1 << d) - 1);
    lo = f ? 0 : -4096;
    if (r > hi || r < lo)
      sat_seen = 1;
    r = r > hi ? hi : r < lo ? lo : r;
    check("mixed_pixel_out_o high", {24'h0, dout[12:5]}, 32'((r & 8191) >> 5));
    check("mixed_pixel_out_o low", {27'h0, dout[4:0]}, 32'(r & 31));
    check("mixed_pixel_oe_n_o", {31'h0, oe_o}, {31'h0, oe_n});
  endtask : check_out

  // ==========================================================================
  // main sequence
  initial
  begin
    {rst_n, mix_en, fmt, oe_n, cyc, stb, we, run, chk} = '0;
    {pa, pb, pm, rnd, adr, wdat} = '0;
    byp = 1'b1;
    void'($urandom(32'hAD5E));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(REG_CTRL, 32'h0, "ctrl");
    rd(REG_STATUS, 32'h2, "status");
    rd(REG_DELAY, 32'h0, "delay");
    rd(4'hC, 32'h0, "unmapped");
    $display("test reset done");
    extremes = 1;
    run = 1;
    settle = 20;
    chk = 1;
    repeat (400) @(posedge clk);
    rd(REG_STATUS, 32'(2 + sat_seen), "status");
    run = 0;
    chk = 0;
    pa <= 12'h000;
    pb <= 12'h000;
    repeat (15) @(posedge clk);
    wb(1'b1, REG_STATUS, 32'h1);
    rd(REG_STATUS, 32'h2, "status");
    $display("test bypass stream done");
    extremes = 0;
    run = 1;
    byp <= 1'b0;
    foreach (words[i])
    begin
      chk = 0;
      i_loader.load(words[i]);
      repeat (6) @(posedge clk);
      rd(REG_DELAY, {17'h0, words[i]}, "delay");
      dw = words[i];
      settle = 30;
      chk = 1;
      repeat (200) @(posedge clk);
    end
    $display("test delay words done");
    wb(1'b1, REG_CTRL, 32'h1);
    dw = 0;
    settle = 30;
    rd(REG_DELAY, 32'h0, "delay");
    rd(REG_CTRL, 32'h1, "ctrl");
    repeat (200) @(posedge clk);
    wb(1'b1, REG_CTRL, 32'h0);
    rd(REG_CTRL, 32'h0, "ctrl");
    $display("test forced bypass done");
    tally_and_finish();
  end
endmodule : weighted_video_mixer_bench
